// file: common/isp_defs.svh
// Purpose: constants for the interrupt steering and priority gate
// Assumes: one system clock, all partners on it
// Notes: included by the package only
//
// What the document asks of this block and its software
// (R1) each dma channel takes its request from one source picked by a select field
// (R2) a claimed on-chip-module source serves only its dma channel; code still raises dma_req on any other channel whose select field picks it
// (R3) unclaimed sources go to the transfer controller if activation bit set, else cpu
// (R4) per-transfer cpu irq select: controller clears activation bit, then cpu sees source
// (R5) transfer count reaching zero clears activation bit, then cpu sees source; code also clears the flag unless per-transfer cpu irq select is set
// (R6) software keeps cpu level no higher than controller and channel levels
// (R7) transfer controller picks pending sources by fixed order, ignoring levels
// (R8) cpu irq for a source waits until its controller transfer has finished
// (R9) steering table: cpu only, controller only with clear, or dma only with clear
// (R10) per-transfer cpu irq select: controller runs without clearing, cpu also interrupted
// (R11) cpu handler clears the peripheral flag itself when cpu services it
// (R12) serial and converter sources cleared when controller or dma touches their register
// (R13) software gives equal levels when one interrupt starts several channels
// (R14) cpu level and each channel level are three-bit fields
// (R15) gating only while level control enable is set, otherwise always enabled
// (R16) controller request held while cpu level exceeds controller level
// (R17) each dma channel held independently while cpu level exceeds its level
// (R18) controller gating level comes only from the controller level field
// (R19) auto tracking makes cpu level follow the mask and ignore software writes
// (R20) mode 0 tracking: mask bit to top bit, lower bits zero
// (R21) mode 2 tracking: three-bit mask copied bit for bit
// (R22) under tracking, each new mask value passes through to cpu level
// (R23) held requests stay pending and gate is re-evaluated every cycle
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH
`define ISP_NSRC 16
`define ISP_SRC_W 4
`define ISP_NCH 4
`define ISP_LVL_W 3
`define ISP_LVL_RST 3'h0
`define ISP_ACT_RST 16'h0000
`endif

// file: common/isp_pkg.sv
// Purpose: types for the interrupt steering and priority gate
// Assumes: isp_defs.svh on the include path
// Notes: none
`include "isp_defs.svh"
package isp_pkg;
    typedef enum logic {
        ISP_ICM0 = 1'b0,
        ISP_ICM2 = 1'b1
    } isp_icm_t;

    typedef struct packed {
        logic [`ISP_SRC_W-1:0] src_sel;
        logic factor_hi;
        logic factor_lo;
        logic xfer_en;
        logic source_claim;
        logic [`ISP_LVL_W-1:0] chan_level;
    } isp_dma_cfg_t;

    typedef struct packed {
        logic valid;
        logic [`ISP_SRC_W-1:0] src;
        logic count_zero;
    } isp_xfer_done_t;
endpackage

// file: hw/isp_ctrl.sv
// Purpose: steer peripheral interrupts to dma, transfer controller or cpu
// Assumes: source flags and partner strobes are on clk_sys
// Notes: lowest source index has highest controller priority
`timescale 1ns/1ps
`default_nettype none
module isp_ctrl
    import isp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [`ISP_NSRC-1:0] src_irq,
    input wire isp_dma_cfg_t [`ISP_NCH-1:0] dma_cfg,
    input wire logic [`ISP_NCH-1:0] dma_done,
    input wire logic act_wr,
    input wire logic [`ISP_NSRC-1:0] act_wdata,
    input wire logic [`ISP_NSRC-1:0] per_xfer_cpu_irq_sel,
    input wire isp_xfer_done_t xfer_done,
    input wire logic level_ctrl_en,
    input wire logic auto_cpu_level_en,
    input wire isp_icm_t int_mode,
    input wire logic cpu_mask_bit,
    input wire logic [`ISP_LVL_W-1:0] cpu_mask_level,
    input wire logic cpu_level_wr,
    input wire logic [`ISP_LVL_W-1:0] cpu_level_wdata,
    input wire logic [`ISP_LVL_W-1:0] xfer_ctrl_level,
    output logic [`ISP_NCH-1:0] dma_req,
    output logic xfer_req,
    output logic [`ISP_SRC_W-1:0] xfer_src,
    output logic [`ISP_NSRC-1:0] cpu_irq,
    output logic [`ISP_NSRC-1:0] src_clear,
    output logic [`ISP_NSRC-1:0] xfer_activate_en,
    output logic [`ISP_LVL_W-1:0] cpu_level
);
    logic [`ISP_LVL_W-1:0] cpu_level_reg;
    logic [`ISP_LVL_W-1:0] cpu_level_next;
    logic [`ISP_NSRC-1:0] act_en_reg;
    logic [`ISP_NSRC-1:0] act_en_next;
    logic [`ISP_NSRC-1:0] claimed;
    logic [`ISP_NSRC-1:0] clr_next;
    logic [`ISP_NSRC-1:0] src_live;
    logic [`ISP_NSRC-1:0] xfer_cand;
    logic pick_found;
    logic [`ISP_SRC_W-1:0] pick_idx;
    logic [`ISP_NCH-1:0] dma_req_next;
    logic xfer_req_reg;
    logic [`ISP_SRC_W-1:0] xfer_src_reg;
    logic [`ISP_NCH-1:0] dma_req_reg;
    logic [`ISP_NSRC-1:0] cpu_irq_reg;
    logic [`ISP_NSRC-1:0] src_clear_reg;

    // true when the requester may run against the cpu level
    function automatic logic gate_ok(input logic en, input logic [`ISP_LVL_W-1:0] cpu,
                                     input logic [`ISP_LVL_W-1:0] lvl);
        return !en || (cpu <= lvl); // R15 R16 R17
    endfunction

    function automatic logic on_chip(input isp_dma_cfg_t c);
        return c.factor_hi && !c.factor_lo && c.xfer_en;
    endfunction

    // cpu level: tracked from the mask or written by software
    always_comb begin
        cpu_level_next = cpu_level_reg;
        if (auto_cpu_level_en) begin // R19 R22
            if (int_mode == ISP_ICM0) begin
                cpu_level_next = {cpu_mask_bit, 2'b00}; // R20
            end else begin
                cpu_level_next = cpu_mask_level; // R21
            end
        end else if (cpu_level_wr) begin
            cpu_level_next = cpu_level_wdata; // R14 R19
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cpu_level_reg <= `ISP_LVL_RST;
        end else begin
            cpu_level_reg <= cpu_level_next;
        end
    end

    // sources owned by a dma channel in on-chip module mode
    always_comb begin
        claimed = '0;
        for (int ch = 0; ch < `ISP_NCH; ch++) begin
            if (on_chip(dma_cfg[ch]) && dma_cfg[ch].source_claim) begin
                claimed[dma_cfg[ch].src_sel] = 1'b1; // R2 R9
            end
        end
    end

    // who clears the peripheral flag this cycle
    always_comb begin
        clr_next = '0;
        if (xfer_done.valid && !per_xfer_cpu_irq_sel[xfer_done.src]) begin
            clr_next[xfer_done.src] = 1'b1; // R9 R12
        end
        for (int ch = 0; ch < `ISP_NCH; ch++) begin
            if (dma_done[ch] && on_chip(dma_cfg[ch]) && dma_cfg[ch].source_claim) begin
                clr_next[dma_cfg[ch].src_sel] = 1'b1; // R9 R12
            end
        end
    end

    // a flag being cleared is hidden so it cannot fire twice
    assign src_live = src_irq & ~src_clear_reg & ~clr_next;
    assign xfer_cand = src_live & act_en_reg & ~claimed; // R3

    // fixed order pick, levels play no part
    always_comb begin
        pick_found = 1'b0;
        pick_idx = '0;
        for (int i = `ISP_NSRC - 1; i >= 0; i--) begin
            if (xfer_cand[i]) begin
                pick_found = 1'b1; // R7
                pick_idx = `ISP_SRC_W'(i);
            end
        end
    end

    // activation bits: hardware clear beats a same-cycle software write
    always_comb begin
        act_en_next = act_wr ? act_wdata : act_en_reg;
        if (xfer_done.valid &&
            (per_xfer_cpu_irq_sel[xfer_done.src] || xfer_done.count_zero)) begin
            act_en_next[xfer_done.src] = 1'b0; // R4 R5
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            act_en_reg <= `ISP_ACT_RST;
        end else begin
            act_en_reg <= act_en_next;
        end
    end

    // dma requests through the select mux, gated per channel
    always_comb begin
        for (int ch = 0; ch < `ISP_NCH; ch++) begin
            dma_req_next[ch] = dma_cfg[ch].xfer_en && src_live[dma_cfg[ch].src_sel] // R1
                && gate_ok(level_ctrl_en, cpu_level_reg, dma_cfg[ch].chan_level); // R17 R23
        end
    end

    // re-evaluated every cycle; held requests reappear when the gate opens
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dma_req_reg <= '0;
            xfer_req_reg <= 1'b0;
            xfer_src_reg <= '0;
        end else begin
            dma_req_reg <= dma_req_next; // R23
            xfer_req_reg <= pick_found
                && gate_ok(level_ctrl_en, cpu_level_reg, xfer_ctrl_level); // R16 R18 R23
            xfer_src_reg <= pick_idx;
        end
    end

    // cpu sees a source only when neither dma nor controller holds it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cpu_irq_reg <= '0;
            src_clear_reg <= '0;
        end else begin
            cpu_irq_reg <= src_live & ~claimed & ~act_en_reg; // R3 R8 R10
            src_clear_reg <= clr_next; // R12
        end
    end

    assign dma_req = dma_req_reg;
    assign xfer_req = xfer_req_reg;
    assign xfer_src = xfer_src_reg;
    assign cpu_irq = cpu_irq_reg;
    assign src_clear = src_clear_reg;
    assign xfer_activate_en = act_en_reg;
    assign cpu_level = cpu_level_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    dma_gate_hold_a: assert property ( // R17
        level_ctrl_en && cpu_level_reg > dma_cfg[0].chan_level |=> !dma_req[0])
        else $error("dma channel 0 ran above cpu level");
    xfer_gate_hold_a: assert property ( // R16
        level_ctrl_en && cpu_level_reg > xfer_ctrl_level |=> !xfer_req)
        else $error("controller ran above cpu level");
    gate_off_a: assert property ( // R15
        !level_ctrl_en && pick_found |=> xfer_req && xfer_src == $past(pick_idx))
        else $error("controller held with gating off");
    auto_mode0_a: assert property ( // R20
        auto_cpu_level_en && int_mode == ISP_ICM0 |=> cpu_level == {$past(cpu_mask_bit), 2'b00})
        else $error("mode 0 tracking wrong");
    auto_mode2_a: assert property ( // R21
        auto_cpu_level_en && int_mode == ISP_ICM2 |=> cpu_level == $past(cpu_mask_level))
        else $error("mode 2 tracking wrong");
    sw_level_a: assert property ( // R19
        !auto_cpu_level_en && cpu_level_wr |=> cpu_level == $past(cpu_level_wdata))
        else $error("software level not taken");
    claim_block_a: assert property ( // R2
        claimed[0] |=> !cpu_irq[0] && !(xfer_req && xfer_src == 4'h0))
        else $error("claimed source leaked");
    per_xfer_cpu_irq_sel_clear_a: assert property ( // R4
        xfer_done.valid && per_xfer_cpu_irq_sel[xfer_done.src] && !claimed[xfer_done.src]
        |=> !xfer_activate_en[$past(xfer_done.src)] && !src_clear[$past(xfer_done.src)])
        else $error("per-transfer clear wrong");
    cpu_wait_a: assert property ( // R8
        act_en_reg[0] |=> !cpu_irq[0])
        else $error("cpu irq before transfer end");
    prio_pick_a: assert property ( // R7
        xfer_req && xfer_src != 4'h0 |-> !$past(xfer_cand[0]))
        else $error("fixed order broken");
    xfer_clear_a: assert property ( // R9
        xfer_done.valid && !per_xfer_cpu_irq_sel[xfer_done.src]
        |=> src_clear[$past(xfer_done.src)] ##1 src_clear == '0 || $past(clr_next) != '0)
        else $error("controller clear missing");

    // gate opens and closes per requester, one cycle after the level compare
    dma_gate_pass_a: assert property ( // R17 R23
        level_ctrl_en && dma_cfg[0].xfer_en && src_live[dma_cfg[0].src_sel]
        && cpu_level_reg <= dma_cfg[0].chan_level |=> dma_req[0])
        else $error("dma channel 0 held below cpu level");
    dma_ungated_a: assert property ( // R15
        !level_ctrl_en && dma_cfg[1].xfer_en && src_live[dma_cfg[1].src_sel] |=> dma_req[1])
        else $error("dma channel 1 held with gating off");
    dma_mux_a: assert property ( // R1
        dma_req[2] |-> $past(dma_cfg[2].xfer_en && src_live[dma_cfg[2].src_sel]))
        else $error("dma channel 2 request without its source");
    dma2_pass_a: assert property ( // R17
        level_ctrl_en && dma_cfg[2].xfer_en && src_live[dma_cfg[2].src_sel]
        && cpu_level_reg <= dma_cfg[2].chan_level |=> dma_req[2])
        else $error("dma channel 2 held below cpu level");
    dma3_hold_a: assert property ( // R17
        level_ctrl_en && cpu_level_reg > dma_cfg[3].chan_level |=> !dma_req[3])
        else $error("dma channel 3 ran above cpu level");
    dma1_hold_a: assert property ( // R17
        level_ctrl_en && cpu_level_reg > dma_cfg[1].chan_level |=> !dma_req[1])
        else $error("dma channel 1 ran above cpu level");
    xfer_gate_pass_a: assert property ( // R16 R23
        level_ctrl_en && pick_found && cpu_level_reg <= xfer_ctrl_level |=> xfer_req)
        else $error("controller held below cpu level");
    top_level_hold_a: assert property ( // R16 R18
        level_ctrl_en && cpu_level == 3'h7 && xfer_ctrl_level != 3'h7 |=> !xfer_req)
        else $error("controller ran under top cpu level");
    xfer_origin_a: assert property ( // R23
        xfer_req |-> $past(pick_found))
        else $error("controller request without candidate");
    xfer_idle_a: assert property ( // R7
        !pick_found |=> !xfer_req)
        else $error("controller request while idle");
    last_pick_a: assert property ( // R7
        xfer_req && xfer_src == 4'hF |-> $past(xfer_cand) == 16'h8000)
        else $error("lowest source skipped");

    // cpu level source selection
    level_hold_a: assert property ( // R19
        !auto_cpu_level_en && !cpu_level_wr |=> $stable(cpu_level))
        else $error("cpu level moved without write");
    sw_refused_a: assert property ( // R19
        auto_cpu_level_en && int_mode == ISP_ICM2 && cpu_level_wr
        |=> cpu_level == $past(cpu_mask_level))
        else $error("software write taken under tracking");
    mode0_low_a: assert property ( // R20
        auto_cpu_level_en && int_mode == ISP_ICM0 |=> cpu_level[1:0] == 2'b00)
        else $error("mode 0 low bits not zero");
    mask_pass_a: assert property ( // R22
        auto_cpu_level_en && int_mode == ISP_ICM0 && cpu_level_wr
        |=> cpu_level[2] == $past(cpu_mask_bit))
        else $error("mask not passed through");

    // routing to the cpu and source clears
    cpu_route_a: assert property ( // R3
        src_live[5] && !claimed[5] && !act_en_reg[5] |=> cpu_irq[5])
        else $error("unclaimed source missed the cpu");
    cpu_hidden_a: assert property ( // R3 R9
        src_irq[9] && act_en_reg[9] |=> !cpu_irq[9])
        else $error("controller source reached the cpu");
    claim_hide_a: assert property ( // R2
        claimed[7] |=> !cpu_irq[7] && !(xfer_req && xfer_src == 4'h7))
        else $error("claimed source 7 leaked");
    count_zero_a: assert property ( // R5
        xfer_done.valid && xfer_done.count_zero |=> !xfer_activate_en[$past(xfer_done.src)])
        else $error("count end did not clear activation");
    act_write_a: assert property ( // R3
        act_wr && !xfer_done.valid |=> xfer_activate_en == $past(act_wdata))
        else $error("activation write lost");
    act_keep_a: assert property ( // R4 R5
        !act_wr && !xfer_done.valid |=> $stable(xfer_activate_en))
        else $error("activation bits moved unprompted");
    dma_clear_a: assert property ( // R12
        dma_done[0] && on_chip(dma_cfg[0]) && dma_cfg[0].source_claim
        |=> src_clear[$past(dma_cfg[0].src_sel)])
        else $error("dma clear missing");
    dma_noclear_a: assert property ( // R9
        dma_done[3] && !dma_cfg[3].source_claim && !xfer_done.valid && dma_done[2:0] == 3'h0
        |=> src_clear == '0)
        else $error("unclaimed dma cleared a source");
    clear_hidden_a: assert property ( // R9
        src_clear[6] |=> !cpu_irq[6] && !(xfer_req && xfer_src == 4'h6))
        else $error("cleared source fired again");

    dma_run_c: cover property (dma_req[0] ##1 dma_done[0]);
    xfer_then_cpu_c: cover property (xfer_req ##[1:20] cpu_irq != '0);
    held_then_go_c: cover property (
        level_ctrl_en && pick_found && !xfer_req ##[1:20] xfer_req);
    mode2_held_c: cover property (
        auto_cpu_level_en && int_mode == ISP_ICM2 && level_ctrl_en && pick_found ##1 !xfer_req);
endmodule
`default_nettype wire

// file: sim/isp_partner.sv
// Purpose: transfer controller and dma partner for the steering block
// Assumes: requests are registered levels on clk_sys
// Notes: one transfer at a time; dly sets a prompt or slow answer
`timescale 1ns/1ps
`default_nettype none
module isp_partner
    import isp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [1:0] dly,
    input wire logic cz,
    input wire logic xfer_req,
    input wire logic [3:0] xfer_src,
    input wire logic [3:0] dma_req,
    output var isp_xfer_done_t xfer_done,
    output logic [3:0] dma_done
);
    logic [2:0] cnt;
    logic [3:0] src;
    always_ff @(posedge clk_sys) begin
        xfer_done <= '0;
        dma_done <= 4'h0;
        if (!reset_n) begin
            cnt <= 3'h0;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
                xfer_done <= '{1'b1, src, cz};
                dma_done <= dma_req;
            end
        end else if (xfer_req) begin
            cnt <= {1'b0, dly} + 3'h1;
            src <= xfer_src;
        end
    end
endmodule
`default_nettype wire

// file: sim/isp_ctrl_tb.sv
// Purpose: self-checking bench for the steering and priority gate
// Assumes: isp_partner answers the transfer requests, and the dma requests standing when a transfer ends
// Notes: a cycle model of the rules is compared every cycle
`timescale 1ns/1ps
`default_nettype none
module isp_ctrl_tb
    import isp_pkg::*;
;
    logic clk_sys;
    logic reset_n = 1'b0;
    logic [15:0] src_irq = 16'h0, act_wdata = 16'h0, pxs = 16'h0;
    logic act_wr = 1'b0, lce = 1'b0, auto = 1'b0, mbit = 1'b0, lwr = 1'b0, cz = 1'b0;
    logic chk_on = 1'b0;
    logic [2:0] mlvl = 3'h0, lwd = 3'h0, xlvl = 3'h0, cpu_level, e_lvl;
    logic [1:0] dly = 2'h0;
    isp_icm_t mode = ISP_ICM0;
    isp_dma_cfg_t [3:0] dma_cfg = '0;
    isp_xfer_done_t xfer_done;
    logic [3:0] dma_done, dma_req, e_dma, xfer_src, e_src;
    logic xfer_req, e_xreq;
    logic [15:0] cpu_irq, src_clear, act, e_irq, e_clr, e_act, claim, nclr, nact, live, cand;
    logic [31:0] seed = 32'h80E4B79F, r, q;
    logic [8:0] rows [4] = '{9'h11B, 9'h19D, 9'h15D, 9'h175};
    int fail_count = 0, checked = 0, n;
    isp_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .src_irq(src_irq),
        .dma_cfg(dma_cfg), .dma_done(dma_done), .act_wr(act_wr), .act_wdata(act_wdata),
        .per_xfer_cpu_irq_sel(pxs), .xfer_done(xfer_done), .level_ctrl_en(lce),
        .auto_cpu_level_en(auto), .int_mode(mode), .cpu_mask_bit(mbit),
        .cpu_mask_level(mlvl), .cpu_level_wr(lwr), .cpu_level_wdata(lwd),
        .xfer_ctrl_level(xlvl), .dma_req(dma_req), .xfer_req(xfer_req), .xfer_src(xfer_src),
        .cpu_irq(cpu_irq), .src_clear(src_clear), .xfer_activate_en(act),
        .cpu_level(cpu_level));
    isp_partner u_far (.clk_sys(clk_sys), .reset_n(reset_n), .dly(dly), .cz(cz),
        .xfer_req(xfer_req), .xfer_src(xfer_src), .dma_req(dma_req),
        .xfer_done(xfer_done), .dma_done(dma_done));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic gate(input logic [2:0] l);
        return !lce || e_lvl <= l;
    endfunction
    // model state lives in the expected outputs themselves
    always @(posedge clk_sys) begin
        claim = 16'h0;
        nclr = 16'h0;
        nact = e_act;
        for (int c = 0; c < 4; c++) begin
            if (dma_cfg[c].xfer_en && dma_cfg[c].factor_hi && !dma_cfg[c].factor_lo
                && dma_cfg[c].source_claim) begin
                claim[dma_cfg[c].src_sel] = 1'b1;
                nclr[dma_cfg[c].src_sel] |= dma_done[c];
            end
        end
        if (act_wr) nact = act_wdata;
        if (xfer_done.valid) begin
            nclr[xfer_done.src] |= !pxs[xfer_done.src];
            if (pxs[xfer_done.src] || xfer_done.count_zero) nact[xfer_done.src] = 1'b0;
        end
        live = src_irq & ~e_clr & ~nclr;
        for (int c = 0; c < 4; c++) e_dma[c] = dma_cfg[c].xfer_en && live[dma_cfg[c].src_sel]
            && gate(dma_cfg[c].chan_level);
        cand = live & e_act & ~claim;
        e_xreq = cand != 16'h0 && gate(xlvl);
        for (int s = 15; s >= 0; s--) if (cand[s]) e_src = s[3:0];
        e_irq = live & ~claim & ~e_act;
        e_clr = nclr;
        e_act = nact;
        if (auto) e_lvl = (mode == ISP_ICM0) ? {mbit, 2'b00} : mlvl;
        else if (lwr) e_lvl = lwd;
        if (!reset_n) {e_dma, e_xreq, e_irq, e_clr, e_act, e_lvl} = '0;
    end
    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_lvl(input logic [2:0] got, input logic [2:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t level got %h exp %h", $time, got, exp);
        end
    endtask
    always @(negedge clk_sys) begin
        if (chk_on) begin
            check_vec({12'h0, dma_req}, {12'h0, e_dma});
            check_vec({15'h0, xfer_req}, {15'h0, e_xreq});
            if (e_xreq) check_vec({12'h0, xfer_src}, {12'h0, e_src});
            check_vec(cpu_irq, e_irq);
            check_vec(src_clear, e_clr);
            check_vec(act, e_act);
            check_lvl(cpu_level, e_lvl);
        end
    end
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic give_verdict();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        tick();
        chk_on = 1'b1;
        repeat (2) tick();
        reset_n = 1'b1;
        src_irq = 16'h0004;
        act_wr = 1'b1;
        act_wdata = 16'h0004;
        lce = 1'b1;
        dma_cfg[0] = '{4'h2, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0};
        for (int i = 0; i < 4; i++) begin
            lwr = 1'b1;
            lwd = rows[i][8:6];
            xlvl = rows[i][5:3];
            dma_cfg[0].chan_level = rows[i][2:0];
            tick();
            {act_wr, lwr} = 2'b00;
            repeat (6) tick();
        end
        $display("test gating rows done");
        auto = 1'b1;
        mbit = 1'b1;
        dma_cfg[0].chan_level = 3'h3;
        repeat (4) tick();
        mbit = 1'b0;
        for (n = 0; n < 20 && xfer_req !== 1'b1; n++) tick();
        if (n == 20) begin
            fail_count++;
            $display("MISMATCH t=%0t mask release wait timed out", $time);
        end
        $display("test mask tracking done");
        for (int k = 0; k < 4000; k++) begin
            r = xs();
            q = xs();
            reset_n = r[31:24] != 8'h0;
            // peripheral drops flags that were cleared or serviced by the cpu
            src_irq = (src_irq & ~src_clear & ~(r[0] ? cpu_irq : 16'h0))
                | (r[3:1] == 3'h0 ? 16'h1 << r[7:4] : 16'h0);
            act_wr = r[10:8] == 3'h0;
            act_wdata = q[15:0];
            if (r[13:11] == 3'h0) begin
                pxs = q[31:16];
                {lce, auto, mbit, lwd, xlvl, mlvl} = q[11:0];
                mode = isp_icm_t'(q[12]);
                dma_cfg = {q, q[11:0]};
            end
            {lwr, cz, dly} = r[17:14];
            tick();
        end
        $display("test random traffic done");
        give_verdict();
    end
endmodule
`default_nettype wire
